/* core/bcs_pkg.sv */
package bcs_pkg;

   // ============================================================
   // Cycle type codes
   typedef enum logic [2:0] {
      CYC_INTA  = 3'h0,
      CYC_IORD  = 3'h1,
      CYC_IOWR  = 3'h2,
      CYC_HALT  = 3'h3,
      CYC_FETCH = 3'h4,
      CYC_MEMRD = 3'h5,
      CYC_MEMWR = 3'h6,
      CYC_IDLE  = 3'h7
   } bcs_cycle_t;

   // ============================================================
   // Address map and upper block window
   localparam int ADDR_W = 20;
   localparam logic [19:0] UPPER_RESET_BASE = 20'hF0000;
   localparam logic [19:0] UPPER_RESET_SIZE = 20'h10000;
   localparam logic [19:0] UPPER_MAX_SIZE = 20'h80000;
   localparam int HINT_TOP_BIT = 19;
   localparam int HINT_LOW_BIT = 16;

   // ============================================================
   // Clock
   localparam real CLK_PERIOD_NS = 4.0;
   localparam int CLK_DIV_FACTOR = 2;

endpackage

/* core/bcs_sync3.sv */
`timescale 1ns/100ps
`default_nettype none
module bcs_sync3 #(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '1
)
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   logic [W-1:0] s1;
   logic [W-1:0] s2;
   logic [W-1:0] s3;

   // ============================================================
   // Three stages; a change counts once stages two and three agree.
   // The stages keep shifting while reset is low, because straps are only
   // driven during reset and must be settled by the time it is released.
   always_ff @(posedge clk)
   begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
      if (!rstn || s2 == s3)
         dout <= s3;
   end
endmodule
`default_nettype wire

/* core/bcs_clk_div.sv */
`timescale 1ns/100ps
`default_nettype none
module bcs_clk_div
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic halve,
   output logic clkEn
);
   logic phase;

   // ============================================================
   // Processor clock enable: every edge, or every second edge when halved.
   always_ff @(posedge clk)
   begin
      if (!rstn)
         phase <= 1'b0;
      else
         phase <= ~phase;
   end

   assign clkEn = ~halve | phase;
endmodule
`default_nettype wire

/* core/bcs_bus_status.sv */
// Summary of operation
// [RULE1] Drive three-bit cycle type code; all ones means passive bus.
// [RULE2] Float cycle type outputs during bus hold or hold acknowledge.
// [RULE3] DMA flag high in phases two to four of DMA cycles, else low.
// [RULE4] Float DMA flag during bus hold and reset.
// [RULE5] Sample clock-halving strap at reset release; low halves processor clock.
// [RULE6] Synchronous ready is active high, sampled directly on processor clock.
// [RULE7] System ties synchronous ready high, or low to defer to async ready.
// [RULE8] Upper select low inside upper block; held high during bus hold.
// [RULE9] Software sets upper block base and size, at most 512 kilobytes.
// [RULE10] After reset upper block is the top 64 kilobytes of memory.
// [RULE11] Both float requests low at reset release float every pin until reset.
// [RULE12] Upper select pin keeps driving during bus hold.
// [RULE13] Vector hint is OR of inverted top address bits, held all cycle.
// [RULE14] Vector hint pin low at reset release enters clock test mode.
// [RULE15] High-byte write enable is OR of high-byte enable and write strobe.
// [RULE16] Low-byte write enable is OR of address bit zero and write strobe.
// [RULE17] Eight-bit variant drives one write enable with early address timing.
// [RULE18] Write strobe asserts for writes; floats in bus hold and reset.
// [RULE19] All float and hold behaviour comes from one bus-grant state. Strap float mode is driven from floatMode instead, not from the grant state.
`timescale 1ns/100ps
`default_nettype none
module bcs_bus_status
   import bcs_pkg::*;
#(
   parameter bit BYTE_BUS = 1'b0
)
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic cycleStart,
   input wire bcs_pkg::bcs_cycle_t cycleType,
   input wire logic cycleDma,
   input wire logic [bcs_pkg::ADDR_W-1:0] cycleAddr,
   input wire logic highByteEnable_n,
   input wire logic holdReq,
   input wire logic syncReadyIn,
   input wire logic asyncReadyIn,
   input wire logic [bcs_pkg::ADDR_W-1:0] upperBase,
   input wire logic [bcs_pkg::ADDR_W-1:0] upperSize,
   input wire logic upperLoad,
   input wire logic clockHalvingStrapIn,
   input wire logic floatRequestAIn,
   input wire logic floatRequestBIn,
   input wire logic vectorTableHintIn,
   output logic holdAck,
   output logic cycleDone,
   output logic busy,
   output logic clockHalved,
   output logic clockTestMode,
   output logic floatMode,
   output logic [2:0] cycleTypeCode,
   output logic [2:0] cycleTypeCodeOe,
   output logic dmaCycleFlag,
   output logic dmaCycleFlagOe,
   output logic upperMemorySelect_n,
   output logic upperMemorySelectOe,
   output logic vectorTableHint,
   output logic vectorTableHintOe,
   output logic highByteWriteEnable_n,
   output logic highByteWriteEnableOe,
   output logic lowByteWriteEnable_n,
   output logic lowByteWriteEnableOe,
   output logic writeStrobe_n,
   output logic writeStrobeOe
);
   import bcs_pkg::*;

   typedef enum logic [2:0] {T1, T2, T3, T4, IDLE} bcs_phase_t;

   // ============================================================
   // Strap capture
   logic [3:0] strapSync;
   logic rstnSeen;
   logic procEn;

   bcs_sync3 #(.W(4), .INIT(4'hF)) u_strap_sync (
      .clk(clk),
      .rstn(rstn),
      .din({clockHalvingStrapIn, floatRequestAIn, floatRequestBIn, vectorTableHintIn}),
      .dout(strapSync)
   );

   // Straps are latched on the first clock after reset release, taking the
   // synchronised level that the pins held while reset was low.
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         rstnSeen <= 1'b0;
         clockHalved <= 1'b0;
         floatMode <= 1'b0;
         clockTestMode <= 1'b0;
      end
      else if (!rstnSeen)
      begin
         rstnSeen <= 1'b1;
         clockHalved <= ~strapSync[3]; // RULE5
         floatMode <= ~strapSync[2] & ~strapSync[1]; // RULE11
         clockTestMode <= ~strapSync[0]; // RULE14
      end
   end

   bcs_clk_div u_clk_div (
      .clk(clk),
      .rstn(rstn),
      .halve(clockHalved), // RULE5
      .clkEn(procEn)
   );

   // ============================================================
   // Upper block configuration
   logic [ADDR_W-1:0] upBase;
   logic [ADDR_W-1:0] upSize;
   wire [ADDR_W-1:0] clampSize = (upperSize > UPPER_MAX_SIZE) ? UPPER_MAX_SIZE : upperSize;

   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         upBase <= UPPER_RESET_BASE; // RULE10
         upSize <= UPPER_RESET_SIZE;
      end
      else if (upperLoad)
      begin
         upBase <= upperBase; // RULE9
         upSize <= clampSize;
      end
   end

   function automatic logic inUpper(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] b,
                                    input logic [ADDR_W-1:0] s);
      logic [ADDR_W:0] top;
      top = {1'b0, b} + {1'b0, s};
      return ({1'b0, a} >= {1'b0, b}) && ({1'b0, a} < top);
   endfunction

   // ============================================================
   // Bus cycle sequencer
   bcs_phase_t phase;
   bcs_phase_t next_phase;
   logic granted;
   bcs_cycle_t curType;
   logic curDma;
   logic [ADDR_W-1:0] curAddr;
   logic curBhe_n;

   // Ready: sync ready taken directly, async ready two stages later.
   logic asyncR1;
   logic asyncR2;
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         asyncR1 <= 1'b0;
         asyncR2 <= 1'b0;
      end
      else
      begin
         asyncR1 <= asyncReadyIn;
         asyncR2 <= asyncR1;
      end
   end
   wire ready = syncReadyIn | asyncR2; // RULE6 RULE7

   // Hold wins over a start requested in the same cycle, so no cycle runs granted.
   wire startOk = cycleStart && !granted && !holdReq && !floatMode;
   wire grantNow = holdReq && (phase == IDLE);
   wire releaseNow = !holdReq && granted;

   always_comb
   begin
      next_phase = phase;
      unique case (phase)
         IDLE: if (startOk) next_phase = T1;
         T1: next_phase = T2;
         T2: next_phase = T3;
         T3: if (ready) next_phase = T4;
         T4: next_phase = IDLE;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         phase <= IDLE;
         granted <= 1'b0;
         curType <= CYC_IDLE;
         curDma <= 1'b0;
         curAddr <= '0;
         curBhe_n <= 1'b1;
      end
      else if (procEn)
      begin
         phase <= next_phase;
         if (grantNow)
            granted <= 1'b1; // RULE19
         else if (releaseNow)
            granted <= 1'b0;
         if (phase == IDLE && startOk)
         begin
            curType <= cycleType;
            curDma <= cycleDma;
            curAddr <= cycleAddr;
            curBhe_n <= highByteEnable_n;
         end
      end
   end

   // ============================================================
   // Output decode from the next state, so every pin is a flip-flop
   wire nextActive = next_phase != IDLE;
   wire [ADDR_W-1:0] nAddr = (phase == IDLE) ? cycleAddr : curAddr;
   bcs_cycle_t nType;
   assign nType = (phase == IDLE) ? cycleType : curType;
   wire nDma = (phase == IDLE) ? cycleDma : curDma;
   wire nBhe_n = (phase == IDLE) ? highByteEnable_n : curBhe_n;
   wire nGrant = grantNow ? 1'b1 : (releaseNow ? 1'b0 : granted);
   wire isWrite = (nType == CYC_MEMWR) || (nType == CYC_IOWR);
   wire nWr_n = ~(nextActive && isWrite && (next_phase == T2 || next_phase == T3)); // RULE18
   wire nLate = next_phase == T2 || next_phase == T3 || next_phase == T4;
   wire nUpper = nextActive && (nType inside {CYC_FETCH, CYC_MEMRD, CYC_MEMWR})
                 && inUpper(nAddr, upBase, upSize);
   wire nHint = |(~nAddr[HINT_TOP_BIT:HINT_LOW_BIT]); // RULE13
   // Float mode takes effect on the same edge at which the straps are latched.
   wire nFloat = rstnSeen ? floatMode : (~strapSync[2] & ~strapSync[1]);
   wire drive = !nFloat; // RULE11
   wire busDrive = drive && !nGrant; // RULE19

   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         cycleTypeCode <= CYC_IDLE;
         cycleTypeCodeOe <= 3'h0;
         dmaCycleFlag <= 1'b0;
         dmaCycleFlagOe <= 1'b0; // RULE4
         upperMemorySelect_n <= 1'b1;
         upperMemorySelectOe <= 1'b1;
         vectorTableHint <= 1'b1;
         vectorTableHintOe <= 1'b0;
         highByteWriteEnable_n <= 1'b1;
         highByteWriteEnableOe <= 1'b0; // RULE15
         lowByteWriteEnable_n <= 1'b1;
         lowByteWriteEnableOe <= 1'b0; // RULE16 RULE17
         writeStrobe_n <= 1'b1;
         writeStrobeOe <= 1'b0; // RULE18
         holdAck <= 1'b0;
         cycleDone <= 1'b0;
         busy <= 1'b0;
      end
      else if (procEn)
      begin
         cycleTypeCode <= nextActive ? nType : CYC_IDLE; // RULE1
         cycleTypeCodeOe <= {3{busDrive}}; // RULE2
         dmaCycleFlag <= nDma && nLate; // RULE3
         dmaCycleFlagOe <= busDrive; // RULE4
         upperMemorySelect_n <= nGrant ? 1'b1 : ~nUpper; // RULE8 RULE10
         upperMemorySelectOe <= drive; // RULE12
         vectorTableHint <= nextActive ? nHint : vectorTableHint; // RULE13
         vectorTableHintOe <= drive;
         if (BYTE_BUS)
         begin
            highByteWriteEnable_n <= 1'b1;
            // Single byte enable follows the early address timing, whole cycle.
            lowByteWriteEnable_n <= ~(nextActive && isWrite); // RULE17
         end
         else
         begin
            highByteWriteEnable_n <= nBhe_n | nWr_n; // RULE15
            lowByteWriteEnable_n <= nAddr[0] | nWr_n; // RULE16
         end
         highByteWriteEnableOe <= busDrive && !BYTE_BUS;
         lowByteWriteEnableOe <= busDrive;
         writeStrobe_n <= nWr_n; // RULE18
         writeStrobeOe <= busDrive; // RULE18
         holdAck <= nGrant;
         cycleDone <= phase == T4;
         busy <= nextActive;
      end
      else
         cycleDone <= 1'b0;
   end
endmodule
`default_nettype wire

/* verif/bcs_bus_status_props.sv */
`timescale 1ns/100ps
`default_nettype none
module bcs_bus_status_props
   import bcs_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic cycleStart,
   input wire bcs_pkg::bcs_cycle_t cycleType,
   input wire logic cycleDma,
   input wire logic [bcs_pkg::ADDR_W-1:0] cycleAddr,
   input wire logic upperLoad,
   input wire logic holdAck,
   input wire logic busy,
   input wire logic clockHalved,
   input wire logic floatMode,
   input wire logic [2:0] cycleTypeCode,
   input wire logic [2:0] cycleTypeCodeOe,
   input wire logic dmaCycleFlag,
   input wire logic dmaCycleFlagOe,
   input wire logic upperMemorySelect_n,
   input wire logic upperMemorySelectOe,
   input wire logic vectorTableHint,
   input wire logic vectorTableHintOe,
   input wire logic highByteWriteEnable_n,
   input wire logic highByteWriteEnableOe,
   input wire logic lowByteWriteEnable_n,
   input wire logic lowByteWriteEnableOe,
   input wire logic writeStrobe_n,
   input wire logic writeStrobeOe
);
   import bcs_pkg::*;
   // ============================================================
   // Cycle tracking
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   logic expHint;
   logic loaded;
   wire isWr = cycleType == CYC_IOWR || cycleType == CYC_MEMWR;
   wire inTop = cycleAddr >= UPPER_RESET_BASE && cycleType inside {CYC_FETCH, CYC_MEMRD, CYC_MEMWR};
   // Once software moves the upper block the reset window no longer predicts the select.
   always_ff @(posedge clk)
   begin
      expHint <= ~&cycleAddr[19:16];
      loaded <= rstn && (loaded || upperLoad);
   end
   sequence taken_s;
      cycleStart && !busy && !holdAck && !floatMode && !clockHalved && cycleTypeCode == CYC_IDLE;
   endsequence
   hold_float_a: assert property (holdAck |-> cycleTypeCodeOe == 3'h0 && !dmaCycleFlagOe && !writeStrobeOe)
      else $error("bus outputs driven while granted");
   hold_select_a: assert property (holdAck && !floatMode |-> upperMemorySelect_n && upperMemorySelectOe)
      else $error("upper select not held high while granted");
   float_all_a: assert property (floatMode |-> !(|{cycleTypeCodeOe, dmaCycleFlagOe, upperMemorySelectOe,
      vectorTableHintOe, highByteWriteEnableOe, lowByteWriteEnableOe, writeStrobeOe}))
      else $error("pin driven in float mode");
   high_or_a: assert property (highByteWriteEnableOe && !highByteWriteEnable_n |-> !writeStrobe_n)
      else $error("high byte enable low without strobe");
   low_or_a: assert property (lowByteWriteEnableOe && !lowByteWriteEnable_n |-> !writeStrobe_n)
      else $error("low byte enable low without strobe");
   type_hint_a: assert property (taken_s |=> cycleTypeCode == $past(cycleType) && vectorTableHint == expHint
      ##1 $stable(vectorTableHint)[*2])
      else $error("cycle code or hint wrong");
   dma_phase_a: assert property (taken_s |=> !dmaCycleFlag ##1 dmaCycleFlag == $past(cycleDma, 2))
      else $error("dma flag phase wrong");
   wr_phase_a: assert property (taken_s |=> writeStrobe_n ##1 writeStrobe_n == !$past(isWr, 2))
      else $error("write strobe phase wrong");
   upper_top_a: assert property (taken_s ##0 !loaded |=> upperMemorySelect_n == !$past(inTop))
      else $error("reset upper window wrong");
endmodule
bind bcs_bus_status bcs_bus_status_props u_props (.*);
`default_nettype wire

/* verif/bcs_ext_model.sv */
`timescale 1ns/100ps
`default_nettype none
module bcs_ext_model
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic [2:0] cycleTypeCode,
   input wire logic [1:0] waits,
   input wire logic [3:0] strapLow,
   output logic syncReadyIn,
   output logic asyncReadyIn,
   output logic clockHalvingStrapIn,
   output logic floatRequestAIn,
   output logic floatRequestBIn,
   output logic vectorTableHintIn
);
   // ============================================================
   // Glue logic
   logic [1:0] cnt = 2'h0;
   logic [2:0] prevCode = 3'h7;
   // Straps sit on pull-ups and are pulled low only while reset is held.
   assign {clockHalvingStrapIn, floatRequestAIn, floatRequestBIn, vectorTableHintIn} = rstn ? 4'hF : ~strapLow;
   assign asyncReadyIn = 1'b0;
   assign syncReadyIn = cnt == 2'h0;
   always_ff @(posedge clk)
   begin
      prevCode <= cycleTypeCode;
      if (!rstn)
         cnt <= 2'h0;
      else if (prevCode == 3'h7 && cycleTypeCode != 3'h7)
         cnt <= waits;
      else if (cnt != 2'h0)
         cnt <= cnt - 2'h1;
   end
endmodule
`default_nettype wire

/* verif/tb_bcs_bus_status.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_bcs_bus_status;
   import bcs_pkg::*;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic cycleStart = 1'b0, cycleDma = 1'b0, highByteEnable_n = 1'b1, holdReq = 1'b0, upperLoad = 1'b0;
   bcs_cycle_t cycleType = CYC_IDLE;
   logic [19:0] cycleAddr = 20'h0, upperBase = 20'h0, upperSize = 20'h0;
   logic syncReadyIn, asyncReadyIn, clockHalvingStrapIn, floatRequestAIn, floatRequestBIn, vectorTableHintIn;
   logic holdAck, cycleDone, busy, clockHalved, clockTestMode, floatMode, dmaCycleFlag, dmaCycleFlagOe;
   logic upperMemorySelect_n, upperMemorySelectOe, vectorTableHint, vectorTableHintOe, writeStrobe_n, writeStrobeOe;
   logic highByteWriteEnable_n, highByteWriteEnableOe, lowByteWriteEnable_n, lowByteWriteEnableOe;
   logic [2:0] cycleTypeCode, cycleTypeCodeOe;
   logic [2:0] prevCode;
   logic [1:0] waits = 2'h0;
   logic [3:0] strapLow = 4'h0;
   logic [3:0] cases[5] = '{4'h8, 4'h4, 4'h1, 4'h0, 4'h6};
   logic [31:0] seed = 32'h45EB;
   logic [8:0] expQ[$];
   logic [8:0] obs;
   logic atT1 = 1'b0;
   logic [19:0] base = UPPER_RESET_BASE, size = UPPER_RESET_SIZE;
   int num_errors = 0, n_compared = 0, cycles = 0;
   bcs_bus_status DUT (.*);
   bcs_ext_model partner (.*);
   initial
   begin
      forever #2 clk = ~clk;
   end
   // ============================================================
   // Helpers
   function logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task chk(input string nm, input logic [8:0] seen, input logic [8:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task summarize();
      $display("errors %0d compared %0d", num_errors, n_compared);
      if (num_errors == 0 && n_compared > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task doReset(input logic [3:0] s);
      strapLow <= s;
      rstn <= 1'b0;
      repeat (8) @(posedge clk);
      chk("resetOe", {cycleTypeCode, dmaCycleFlagOe, writeStrobeOe, highByteWriteEnableOe, lowByteWriteEnableOe,
         upperMemorySelectOe, upperMemorySelect_n}, 9'h1C3);
      rstn <= 1'b1;
      repeat (3) @(posedge clk);
   endtask
   // The expectation is queued before the start so the monitor never finds it missing.
   task runCycle(input bcs_cycle_t t, input logic [19:0] a, input logic d);
      logic wrN;
      wrN = !(t inside {CYC_IOWR, CYC_MEMWR});
      expQ.push_back({t, ~&a[19:16], !(t inside {CYC_FETCH, CYC_MEMRD, CYC_MEMWR} && a - base < size), d, wrN,
         a[1] | wrN, a[0] | wrN});
      cycleType <= t;
      cycleAddr <= a;
      cycleDma <= d;
      highByteEnable_n <= a[1];
      cycleStart <= 1'b1;
      @(posedge clk);
      cycleStart <= 1'b0;
      for (int i = 0; i < 30 && cycleDone !== 1'b1; i++)
         @(posedge clk);
   endtask
   // ============================================================
   // Monitor
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         num_errors++;
         summarize();
      end
      prevCode <= cycleTypeCode;
      atT1 <= 1'b0;
      if (cycleTypeCodeOe == 3'h7 && cycleTypeCode != 3'h7 && prevCode == 3'h7)
      begin
         obs[8:4] <= {cycleTypeCode, vectorTableHint, upperMemorySelect_n};
         atT1 <= 1'b1;
      end
      if (atT1)
         obs[3:0] <= {dmaCycleFlag, writeStrobe_n, highByteWriteEnable_n, lowByteWriteEnable_n};
      if (cycleDone === 1'b1)
         chk("cycle", obs, expQ.size() > 0 ? expQ.pop_front() : 9'h1FF);
   end
   // ============================================================
   // Stimulus
   initial
   begin
      foreach (cases[i])
      begin
         doReset(cases[i]);
         chk("straps", {6'h0, clockHalved, floatMode, clockTestMode},
            {6'h0, cases[i][3], &cases[i][2:1], cases[i][0]});
      end
      cycleStart <= 1'b1;
      repeat (4) @(posedge clk);
      cycleStart <= 1'b0;
      chk("floatIdle", {8'h0, busy}, 9'h0);
      doReset(4'h0);
      holdReq <= 1'b1;
      for (int i = 0; i < 20 && holdAck !== 1'b1; i++)
         @(posedge clk);
      cycleStart <= 1'b1;
      repeat (3) @(posedge clk);
      chk("hold", {cycleTypeCodeOe, dmaCycleFlagOe, writeStrobeOe, upperMemorySelectOe, upperMemorySelect_n, busy,
         1'b0}, 9'h00C);
      cycleStart <= 1'b0;
      holdReq <= 1'b0;
      repeat (3) @(posedge clk);
      runCycle(CYC_FETCH, 20'hFFFF0, 1'b0);
      runCycle(CYC_MEMRD, 20'hEFFFF, 1'b1);
      runCycle(CYC_MEMWR, 20'hF0000, 1'b1);
      for (int i = 0; i < 60; i++)
      begin
         seed = lfsr(seed);
         waits <= seed[22:21];
         runCycle(bcs_cycle_t'(i < 7 ? i : seed % 7), seed[19:0], seed[20]);
      end
      upperBase <= 20'h00000;
      upperSize <= 20'hFFFFF;
      upperLoad <= 1'b1;
      @(posedge clk);
      upperLoad <= 1'b0;
      base = 20'h00000;
      size = UPPER_MAX_SIZE;
      runCycle(CYC_MEMRD, 20'h7FFFF, 1'b0);
      runCycle(CYC_MEMWR, 20'h80000, 1'b0);
      runCycle(CYC_FETCH, 20'hFFFF0, 1'b0);
      repeat (4) @(posedge clk);
      chk("pending", 9'(expQ.size()), 9'h0);
      summarize();
   end
endmodule
`default_nettype wire
